// ===== bench/mio_ctrl_asserts.sv
// mio_ctrl_asserts: port-level checks on mio_ctrl, bound into it.
// assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
module mio_ctrl_asserts (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // bus answers
  input wire logic i_bready,
  input wire logic o_bvalid,
  input wire logic [1:0] o_bresp,
  input wire logic i_rready,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  // pads and power
  input wire mio_pkg::mio_pads_t o_pads,
  input wire logic i_cpu_active,
  input wire logic i_clk_needed,
  input wire logic o_baud_tick,
  input wire logic [3:0] o_pwr_state
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // ******************************
  // helper and assertions
  // ******************************
  // cycles since the last baud tick, saturating
  logic [7:0] gap_reg;
  logic [7:0] gap_next;
  always_comb begin
    gap_next = gap_reg;
    if (o_baud_tick) gap_next = 8'h00;
    else if (gap_reg != 8'hff) gap_next = gap_reg + 8'h01;
  end
  // saturated at reset: the first tick is never judged
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) gap_reg <= 8'hff;
    else gap_reg <= gap_next;
  end
  baud_gap_a: assert property (o_baud_tick |-> gap_reg >= 8'h63)
    else $error("baud ticks too close");
  conv_pin_a: assert property (!o_pads.oe_n[15] &&
    o_pads.out[15] == (o_pwr_state == 4'h1))
    else $error("converter pin wrong");
  cpu_wakes_a: assert property (i_cpu_active |=> o_pwr_state == 4'h1)
    else $error("not active while busy");
  deep_cause_a: assert property (o_pwr_state == 4'h8 |->
    $past(!i_cpu_active && !i_clk_needed))
    else $error("deep sleep too early");
  fe_pins_a: assert property (o_pads.oe_n[9:8] == 2'b00 &&
    o_pads.pu[9:8] == 2'b00 && o_pads.pd[9:8] == 2'b00)
    else $error("front-end pins free");
  pull_excl_a: assert property ((o_pads.pu & o_pads.pd) == 24'h0)
    else $error("both pulls on");
  port_pull_a: assert property (!(|o_pads.pu[7:0] && |o_pads.pd[7:0])
    && !(|o_pads.pu[15:8] && |o_pads.pd[15:8])
    && !(|o_pads.pu[23:16] && |o_pads.pd[23:16]))
    else $error("mixed pulls in port");
  reset_pull_a: assert property ($rose(i_rstn) |->
    (o_pads.pu | 24'h008300) == 24'hffffff &&
    (o_pads.oe_n | 24'h008300) == 24'hffffff)
    else $error("bad reset pads");
  bresp_hold_a: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp))
    else $error("bresp dropped");
  rdata_hold_a: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata))
    else $error("rdata dropped");
  // main scenarios reached
  wr_c: cover property (o_bvalid && i_bready);
  medium_c: cover property (o_pwr_state == 4'h4);
  tick_c: cover property (o_baud_tick);
endmodule : mio_ctrl_asserts

bind mio_ctrl mio_ctrl_asserts u_chk (.i_ref_clk(i_ref_clk),
  .i_rstn(i_rstn), .i_bready(i_bready), .o_bvalid(o_bvalid),
  .o_bresp(o_bresp), .i_rready(i_rready), .o_rvalid(o_rvalid),
  .o_rdata(o_rdata), .o_pads(o_pads), .i_cpu_active(i_cpu_active),
  .i_clk_needed(i_clk_needed), .o_baud_tick(o_baud_tick),
  .o_pwr_state(o_pwr_state));

// ===== bench/mio_pad_model.sv
// mio_pad_model: the board around the pads; resolves each pin level.
// assumes the block drive wins over the outside driver.
`timescale 1ns/1ps
module mio_pad_model (
  // clock
  input wire logic i_ref_clk,
  // block drive and outside driver
  input wire mio_pkg::mio_pads_t i_pads,
  input wire logic [23:0] i_ext_val,
  input wire logic [23:0] i_ext_en,
  // resolved levels
  output logic [23:0] o_pin
);
  // floating pins toggle, so a stale value cannot pass
  logic [23:0] float_reg = 24'h0;
  always @(posedge i_ref_clk) float_reg <= ~float_reg;
  // priority: block drive, outside driver, pull-up, pull-down
  always_comb begin
    for (int n = 0; n < 24; n++) begin
      if (!i_pads.oe_n[n]) o_pin[n] = i_pads.out[n];
      else if (i_ext_en[n]) o_pin[n] = i_ext_val[n];
      else if (i_pads.pu[n]) o_pin[n] = 1'b1;
      else if (i_pads.pd[n]) o_pin[n] = 1'b0;
      else o_pin[n] = float_reg[n];
    end
  end
endmodule : mio_pad_model

// ===== bench/tb_mio_ctrl.sv
// tb_mio_ctrl: random and corner tests of mio_ctrl.
// assumes the pad model on the pins and the bound checker.
`timescale 1ns/1ps
module tb_mio_ctrl;
  logic ref_clk = 1'b0, rstn = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0;
  logic [23:0] peri_out = 0, peri_oe = 0, ext_val = 0, ext_en = 0, pin;
  logic [1:0] fe = 2'h0;
  logic cpu_active = 1'b1, clk_needed = 1'b1;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_baud_tick;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [3:0] o_pwr_state;
  mio_pkg::mio_pads_t o_pads;
  int num_errors = 0, n_tests = 0, cyc = 0;
  always #2.5 ref_clk = ~ref_clk;
  mio_ctrl uut (.i_ref_clk(ref_clk), .i_rstn(rstn), .i_ce(1'b1),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(o_awready),
    .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .i_rready(rready), .i_pin_in(pin),
    .o_pads(o_pads), .i_peri_out(peri_out), .i_peri_oe(peri_oe),
    .i_fe_ctrl(fe), .i_cpu_active(cpu_active),
    .i_clk_needed(clk_needed), .o_baud_tick(o_baud_tick),
    .o_pwr_state(o_pwr_state));
  mio_pad_model u_pads (.i_ref_clk(ref_clk), .i_pads(o_pads),
    .i_ext_val(ext_val), .i_ext_en(ext_en), .o_pin(pin));
  // ******************************
  // reporting and bus master
  // ******************************
  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // run is about 60k cycles; a hang stops at the ceiling
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 100000) begin
      num_errors++;
      end_of_test();
    end
  end
  // readies and valids as the next rising edge sees them
  logic aw_r, w_r, b_r, ar_r, r_r;
  always @(negedge ref_clk) {aw_r, w_r, b_r, ar_r, r_r} <=
    {o_awready, o_wready, o_bvalid, o_arready, o_rvalid};
  // bus master: lets an edge pass so calls never overlap
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] rs);
    @(posedge ref_clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1;
    bready <= 1'b1;
    // either channel may be taken first
    do begin
      @(posedge ref_clk);
      if (aw_r) awvalid <= 1'b0;
      if (w_r) wvalid <= 1'b0;
    end while (awvalid && !aw_r || wvalid && !w_r);
    do @(posedge ref_clk); while (!b_r);
    rs = o_bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] rs);
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge ref_clk); while (!ar_r);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!r_r);
    d = o_rdata;
    rs = o_rresp;
    rready <= 1'b0;
  endtask : rd
  // ******************************
  // expectation helpers and tests
  // ******************************
  function automatic logic [3:0] exp_pwr(logic osc, logic [1:0] cap,
      logic need);
    if (!need && cap == 2'h3) return 4'h8;
    if (osc && cap >= 2'h2 && !need) return 4'h4;
    if (osc && cap >= 2'h1) return 4'h2;
    return 4'h1;
  endfunction : exp_pwr
  task automatic chk_rst();
    check("reset pu", o_pads.pu | 24'h008300, 24'hffffff);
    check("reset oe_n", o_pads.oe_n | 24'h008300, 24'hffffff);
  endtask : chk_rst
  // random port setups; the first drives all pins of port 0
  task automatic t_ports();
    logic [7:0] d, o, t, pe, known, lvl;
    logic [31:0] r;
    logic [1:0] rs;
    logic dn, eoe, eout;
    int p, i;
    for (int k = 0; k < 24; k++) begin
      p = k % 3; d = $urandom; o = $urandom; t = $urandom;
      pe = (k == 0) ? 8'h00 : 8'($urandom); dn = $urandom;
      if (k == 0) d = 8'hff;
      wr(mio_pkg::OFS_DIR0 + 8'(4 * p), {24'h0, d}, rs);
      wr(mio_pkg::OFS_OUT0 + 8'(4 * p), {24'h0, o}, rs);
      wr(mio_pkg::OFS_TRI0 + 8'(4 * p), {24'h0, t}, rs);
      wr(mio_pkg::OFS_PERI0 + 8'(4 * p), {24'h0, pe}, rs);
      wr(mio_pkg::OFS_PULLDN, 32'(dn) << p, rs);
      peri_out <= $urandom; peri_oe <= $urandom; fe <= $urandom;
      ext_val <= $urandom; ext_en <= $urandom;
      repeat (3) @(posedge ref_clk);
      known = 8'h0;
      lvl = 8'h0;
      for (int n = 0; n < 8; n++) begin
        i = 8 * p + n;
        if (p == 1 && mio_pkg::RESERVED_MASK[n]) continue;
        eoe = pe[n] ? ~peri_oe[i] : ~d[n];
        eout = pe[n] ? peri_out[i] : o[n];
        check("pad oe_n", o_pads.oe_n[i], eoe);
        if (!eoe) check("pad out", o_pads.out[i], eout);
        else check("pad pulls", {o_pads.pu[i], o_pads.pd[i]},
          {!pe[n] && !t[n] && !dn, !pe[n] && !t[n] && dn});
        known[n] = !eoe || ext_en[i] || (!pe[n] && !t[n]);
        lvl[n] = !eoe ? eout : ext_en[i] ? ext_val[i] : !dn;
      end
      rd(mio_pkg::OFS_IN0 + 8'(4 * p), r, rs);
      check("pin read", r[7:0] & known, lvl & known);
    end
  endtask : t_ports
  // every sleep setting against both clock demands
  task automatic t_pwr();
    logic [31:0] r;
    logic [1:0] rs;
    logic [3:0] e;
    cpu_active <= 1'b0;
    for (int c = 0; c < 16; c++) begin
      wr(mio_pkg::OFS_SLEEP, 32'(c[2:0]), rs);
      clk_needed <= c[3];
      repeat (3) @(posedge ref_clk);
      e = exp_pwr(c[0], c[2:1], c[3]);
      check("power state", o_pwr_state, e);
      rd(mio_pkg::OFS_STATUS, r, rs);
      check("status", r[4:0], {e == 4'h1, e});
    end
    cpu_active <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check("wake", o_pwr_state, 4'h1);
  endtask : t_pwr
  // n bit periods timed against the rate top
  task automatic t_baud(input longint rate, input longint top, int n);
    longint dv, t0, err;
    logic [1:0] rs;
    dv = (longint'(mio_pkg::CLK_HZ) * 256 + rate / 2) / rate;
    wr(mio_pkg::OFS_BAUD, 32'(dv), rs);
    repeat (2) do @(posedge ref_clk); while (!o_baud_tick);
    t0 = cyc;
    repeat (n) do @(posedge ref_clk); while (!o_baud_tick);
    err = (cyc - t0) * top - n * longint'(mio_pkg::CLK_HZ);
    if (err < 0) err = -err;
    check("rate error", err * 10000 <= 14 * n * mio_pkg::CLK_HZ, 1);
  endtask : t_baud
  initial begin
    logic [31:0] r;
    logic [1:0] rs;
    void'($urandom(28));
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    chk_rst();
    rd(mio_pkg::OFS_BAUD, r, rs);
    check("baud reset", r, 32'h145855);
    rd(mio_pkg::OFS_SLEEP, r, rs);
    check("sleep reset", r, 32'h6);
    wr(8'h4c, 32'h1, rs);
    check("unmapped bresp", rs, 2'h2);
    wr(mio_pkg::OFS_IN0, 32'hff, rs);
    check("read-only bresp", rs, 2'h0);
    rd(8'h02, r, rs);
    check("unaligned rresp", {r[29:0], rs}, 32'h2);
    $display("test registers done");
    t_ports();
    $display("test ports done");
    // second reset in mid-run overrides the random setup
    rstn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    chk_rst();
    $display("test reset done");
    t_pwr();
    $display("test power done");
    t_baud(230400, 230400, 8);
    t_baud(115200, 115200, 4);
    t_baud(57600, 57600, 3);
    t_baud(38400, 38400, 2);
    t_baud(4000000, 2000000, 8);
    $display("test baud done");
    end_of_test();
  end
endmodule : tb_mio_ctrl

// ===== hw/mio_baud_gen.sv
// mio_baud_gen: fractional baud tick generator, 16.8 fixed-point divisor.
// assumes nothing of when the divisor changes.
`timescale 1ns/1ps
module mio_baud_gen (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // divisor in clock cycles per bit, 8 fraction bits
  input wire logic [23:0] i_div,
  // one-cycle tick per bit period
  output logic o_tick
);

  logic [23:0] acc_reg; // fractional phase accumulator
  logic [23:0] acc_next;
  logic tick_reg;
  logic tick_next;

  // ****************************************************************
  // phase accumulator
  // ****************************************************************
  // the fraction keeps the long-run error to the divisor's rounding,
  // well under the 0.14 percent budget for every standard rate
  always_comb begin
    acc_next = acc_reg + 24'h000100;
    tick_next = 1'b0;
    if (acc_next >= i_div) begin
      acc_next = acc_next - i_div;
      tick_next = 1'b1;
      // a shrunken divisor restarts the phase: no tick burst
      if (acc_next >= i_div) acc_next = 24'h000000;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      acc_reg <= 24'h000000;
      tick_reg <= 1'b0;
    end else if (i_ce) begin
      acc_reg <= acc_next;
      tick_reg <= tick_next;
    end
  end

  assign o_tick = tick_reg;

endmodule : mio_baud_gen

// ===== hw/mio_ctrl.sv
// mio_ctrl: three 8-bit general-purpose ports, converter steering pin,
// uart baud tick and sleep-mode selection behind an axi4-lite slave.
// assumes pads resolve out/oe_n/pu/pd; pins sampled synchronously.
`timescale 1ns/1ps

// What this block does
// - each port pin except the reserved ones individually input or output
// - inputs pull-up, pull-down or tri-state
// - pull direction chosen per whole port
// - reset makes all pins except the reserved ones pulled-up inputs
// - peripheral pins get no pulls
// - front-end pins a and b are reserved
// - converter pin fixed output, not configurable
// - converter on when active, bypass otherwise
// - baud rate configurable up to 2 Mbps
// - standard rates within 0.14 percent error
// - light/medium sleep need sleep oscillator
// - deep sleep when idle unless depth capped
module mio_ctrl (
  // clock, reset and enable
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // axi4-lite write address and data
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // axi4-lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // pads
  input wire logic [23:0] i_pin_in,
  output mio_pkg::mio_pads_t o_pads,
  // peripheral outputs, used when a pin is handed to a peripheral
  input wire logic [23:0] i_peri_out,
  input wire logic [23:0] i_peri_oe,
  // front-end control for the two reserved high-drive pins
  input wire logic [1:0] i_fe_ctrl,
  // processor activity and clock demand
  input wire logic i_cpu_active,
  input wire logic i_clk_needed,
  // uart bit tick and power state
  output logic o_baud_tick,
  output logic [3:0] o_pwr_state
);

  localparam int NP = mio_pkg::NUM_PORTS;
  localparam int W = mio_pkg::PORT_W;

  // ****************************************************************
  // configuration state
  // ****************************************************************
  logic [NP*W-1:0] dir_reg, dir_next;   // 1 = output
  logic [NP*W-1:0] out_reg, out_next;   // output data
  logic [NP*W-1:0] tri_reg, tri_next;   // tri-state inputs
  logic [NP*W-1:0] peri_reg, peri_next; // peripheral function
  logic [NP-1:0] pulldn_reg, pulldn_next; // per-port pull direction
  logic [23:0] baud_reg, baud_next;
  logic [2:0] sleep_reg, sleep_next;
  logic [NP*W-1:0] in_reg, in_next;     // sampled pin levels
  // bus state
  logic aw_held_reg, aw_held_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic w_held_reg, w_held_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  // power state
  mio_pkg::mio_pwr_t pwr_reg, pwr_next;
  logic conv_reg, conv_next;
  logic do_write;

  // merge one byte under strobe
  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    merge8 = s[0] ? d[7:0] : old;
  endfunction : merge8

  // does an offset name a writable or readable register
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= mio_pkg::OFS_STATUS) && (a[1:0] == 2'b00);
  endfunction : mapped

  // ****************************************************************
  // axi4-lite slave and register writes
  // ****************************************************************
  // address and data are latched independently so either may come
  // first; the response waits until both are present
  assign o_awready = !aw_held_reg && !bvalid_reg;
  assign o_wready = !w_held_reg && !bvalid_reg;
  assign o_arready = !rvalid_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

  always_comb begin
    aw_held_next = aw_held_reg;
    awaddr_next = awaddr_reg;
    w_held_next = w_held_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    dir_next = dir_reg;
    out_next = out_reg;
    tri_next = tri_reg;
    peri_next = peri_reg;
    pulldn_next = pulldn_reg;
    baud_next = baud_reg;
    sleep_next = sleep_reg;
    if (i_awvalid && o_awready) begin
      aw_held_next = 1'b1;
      awaddr_next = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      w_held_next = 1'b1;
      wdata_next = i_wdata;
      wstrb_next = i_wstrb;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = mapped(awaddr_reg) ? 2'b00 : 2'b10;
      for (int p = 0; p < NP; p++) begin
        // each pin has its own direction and tri-state bit
        if (awaddr_reg == mio_pkg::OFS_DIR0 + 8'(4*p)) begin
          dir_next[p*W +: W] =
            merge8(dir_reg[p*W +: W], wdata_reg, wstrb_reg);
        end
        if (awaddr_reg == mio_pkg::OFS_OUT0 + 8'(4*p)) begin
          out_next[p*W +: W] =
            merge8(out_reg[p*W +: W], wdata_reg, wstrb_reg);
        end
        if (awaddr_reg == mio_pkg::OFS_TRI0 + 8'(4*p)) begin
          tri_next[p*W +: W] =
            merge8(tri_reg[p*W +: W], wdata_reg, wstrb_reg);
        end
        if (awaddr_reg == mio_pkg::OFS_PERI0 + 8'(4*p)) begin
          peri_next[p*W +: W] =
            merge8(peri_reg[p*W +: W], wdata_reg, wstrb_reg);
        end
      end
      // pull direction is one bit per port, never per pin
      if (awaddr_reg == mio_pkg::OFS_PULLDN && wstrb_reg[0]) begin
        pulldn_next = wdata_reg[NP-1:0];
      end
      if (awaddr_reg == mio_pkg::OFS_BAUD) begin
        for (int b = 0; b < 3; b++) begin
          if (wstrb_reg[b]) begin
            baud_next[b*8 +: 8] = wdata_reg[b*8 +: 8];
          end
        end
        // clamp so the rate never exceeds 2 Mbps
        if (baud_next < mio_pkg::BAUD_MIN) begin
          baud_next = mio_pkg::BAUD_MIN;
        end
      end
      if (awaddr_reg == mio_pkg::OFS_SLEEP && wstrb_reg[0]) begin
        sleep_next = wdata_reg[2:0];
      end
    end
    if (bvalid_reg && i_bready) begin
      bvalid_next = 1'b0;
    end
  end

  // ****************************************************************
  // register reads
  // ****************************************************************
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (i_arvalid && o_arready) begin
      rvalid_next = 1'b1;
      rresp_next = mapped(i_araddr) ? 2'b00 : 2'b10;
      rdata_next = 32'h00000000;
      for (int p = 0; p < NP; p++) begin
        if (i_araddr == mio_pkg::OFS_DIR0 + 8'(4*p))
          rdata_next[7:0] = dir_reg[p*W +: W];
        if (i_araddr == mio_pkg::OFS_OUT0 + 8'(4*p))
          rdata_next[7:0] = out_reg[p*W +: W];
        if (i_araddr == mio_pkg::OFS_IN0 + 8'(4*p))
          rdata_next[7:0] = in_reg[p*W +: W];
        if (i_araddr == mio_pkg::OFS_TRI0 + 8'(4*p))
          rdata_next[7:0] = tri_reg[p*W +: W];
        if (i_araddr == mio_pkg::OFS_PERI0 + 8'(4*p))
          rdata_next[7:0] = peri_reg[p*W +: W];
      end
      if (i_araddr == mio_pkg::OFS_PULLDN)
        rdata_next[NP-1:0] = pulldn_reg;
      if (i_araddr == mio_pkg::OFS_BAUD)
        rdata_next[23:0] = baud_reg;
      if (i_araddr == mio_pkg::OFS_SLEEP)
        rdata_next[2:0] = sleep_reg;
      if (i_araddr == mio_pkg::OFS_STATUS)
        rdata_next[4:0] = {conv_reg, pwr_reg};
    end else if (rvalid_reg && i_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // ****************************************************************
  // power mode selection and converter steering
  // ****************************************************************
  always_comb begin
    logic [1:0] cap;
    cap = sleep_reg[mio_pkg::SLP_MAX_LSB +: 2];
    pwr_next = mio_pkg::PWR_ACTIVE;
    in_next = i_pin_in;
    if (!i_cpu_active) begin
      if (!i_clk_needed && cap == 2'd3) begin
        pwr_next = mio_pkg::PWR_DEEP;
      end else if (sleep_reg[mio_pkg::SLP_OSC_BIT]) begin
        // light and medium sleep keep the sleep oscillator running
        if (cap >= 2'd2 && !i_clk_needed)
          pwr_next = mio_pkg::PWR_MEDIUM;
        else if (cap >= 2'd1)
          pwr_next = mio_pkg::PWR_LIGHT;
      end
    end
    // converter on while active, bypass in any sleep
    conv_next = (pwr_next == mio_pkg::PWR_ACTIVE);
  end

  // ****************************************************************
  // state registers
  // ****************************************************************
  // reset puts every pin except the reserved ones into pulled-up input mode
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dir_reg <= {NP{mio_pkg::RST_DIR}};
      out_reg <= '0;
      tri_reg <= {NP{mio_pkg::RST_TRI}};
      peri_reg <= '0;
      pulldn_reg <= mio_pkg::RST_PULLDN;
      baud_reg <= mio_pkg::RST_BAUD;
      sleep_reg <= mio_pkg::RST_SLEEP;
      in_reg <= '0;
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'b00;
      pwr_reg <= mio_pkg::PWR_ACTIVE;
      conv_reg <= 1'b1;
    end else if (i_ce) begin
      dir_reg <= dir_next;
      out_reg <= out_next;
      tri_reg <= tri_next;
      peri_reg <= peri_next;
      pulldn_reg <= pulldn_next;
      baud_reg <= baud_next;
      sleep_reg <= sleep_next;
      in_reg <= in_next;
      aw_held_reg <= aw_held_next;
      awaddr_reg <= awaddr_next;
      w_held_reg <= w_held_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      pwr_reg <= pwr_next;
      conv_reg <= conv_next;
    end
  end

  // ****************************************************************
  // pad drive
  // ****************************************************************
  // pads are combinational from registers and peripheral/front-end inputs; reserved pins ignore config
  always_comb begin
    for (int i = 0; i < NP*W; i++) begin
      logic pulled;
      pulled = !dir_reg[i] && !tri_reg[i] && !peri_reg[i];
      o_pads.out[i] = peri_reg[i] ? i_peri_out[i] : out_reg[i];
      o_pads.oe_n[i] = peri_reg[i] ? !i_peri_oe[i] : !dir_reg[i];
      o_pads.pu[i] = pulled && !pulldn_reg[i/W];
      o_pads.pd[i] = pulled && pulldn_reg[i/W];
    end
    // front-end pins follow the radio, never the application
    o_pads.out[W+mio_pkg::FE_A_BIT] = i_fe_ctrl[0];
    o_pads.out[W+mio_pkg::FE_B_BIT] = i_fe_ctrl[1];
    o_pads.out[W+mio_pkg::CONV_BIT] = conv_reg;
    for (int j = 0; j < W; j++) begin
      if (mio_pkg::RESERVED_MASK[j]) begin
        o_pads.oe_n[W+j] = 1'b0;
        o_pads.pu[W+j] = 1'b0;
        o_pads.pd[W+j] = 1'b0;
      end
    end
  end

  // ****************************************************************
  // baud generator and outputs
  // ****************************************************************
  mio_baud_gen u_baud (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_div(baud_reg),
    .o_tick(o_baud_tick)
  );

  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
  assign o_pwr_state = pwr_reg;

endmodule : mio_ctrl

// ===== hw/mio_pkg.sv
// mio_pkg: register map, field layout, reset values and timing constants
// for the port configuration, converter steering, baud and sleep block.
// assumes a single 200 MHz clock and a 32-bit axi4-lite register bus.
package mio_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int PORT_W = 8;            // pins per port
  localparam int NUM_PORTS = 3;         // ports 0..2
  localparam int CLK_HZ = 200000000;    // system clock rate

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_DIR0 = 8'h00;   // direction, 1 = output
  localparam logic [7:0] OFS_DIR1 = 8'h04;
  localparam logic [7:0] OFS_DIR2 = 8'h08;
  localparam logic [7:0] OFS_OUT0 = 8'h0c;   // output data
  localparam logic [7:0] OFS_OUT1 = 8'h10;
  localparam logic [7:0] OFS_OUT2 = 8'h14;
  localparam logic [7:0] OFS_IN0 = 8'h18;    // sampled levels, read only
  localparam logic [7:0] OFS_IN1 = 8'h1c;
  localparam logic [7:0] OFS_IN2 = 8'h20;
  localparam logic [7:0] OFS_TRI0 = 8'h24;   // 1 = tri-state input
  localparam logic [7:0] OFS_TRI1 = 8'h28;
  localparam logic [7:0] OFS_TRI2 = 8'h2c;
  localparam logic [7:0] OFS_PERI0 = 8'h30;  // 1 = peripheral function
  localparam logic [7:0] OFS_PERI1 = 8'h34;
  localparam logic [7:0] OFS_PERI2 = 8'h38;
  localparam logic [7:0] OFS_PULLDN = 8'h3c; // bit p: port p pulls down
  localparam logic [7:0] OFS_BAUD = 8'h40;   // baud divisor, 16.8 format
  localparam logic [7:0] OFS_SLEEP = 8'h44;  // sleep configuration
  localparam logic [7:0] OFS_STATUS = 8'h48; // power state, read only

  // ****************************************************************
  // reset values and fields
  // ****************************************************************
  localparam logic [7:0] RST_DIR = 8'h00;    // all inputs
  localparam logic [7:0] RST_TRI = 8'h00;    // pulled, not tri-state
  localparam logic [2:0] RST_PULLDN = 3'h0;  // pulls point up
  // 38400 baud: 200e6/38400 = 5208.33 -> 16.8 fixed point
  localparam logic [23:0] RST_BAUD = 24'h145855;
  // divisor floor: 200e6 / 2e6 = 100, so 2 Mbps is the top rate
  localparam logic [23:0] BAUD_MIN = 24'h006400;
  localparam int SLP_OSC_BIT = 0;            // sleep oscillator enable
  localparam int SLP_MAX_LSB = 1;            // max depth field, 2 bits
  localparam logic [2:0] RST_SLEEP = 3'h6;   // osc off, max depth 3
  // reserved pins on port 1
  localparam int FE_A_BIT = 0;
  localparam int FE_B_BIT = 1;
  localparam int CONV_BIT = 7;
  localparam logic [7:0] RESERVED_MASK = 8'h83;

  // ****************************************************************
  // carriers and states
  // ****************************************************************
  typedef struct packed {
    logic [NUM_PORTS*PORT_W-1:0] out;   // pin drive value
    logic [NUM_PORTS*PORT_W-1:0] oe_n;  // low while driven
    logic [NUM_PORTS*PORT_W-1:0] pu;    // pull-up enable
    logic [NUM_PORTS*PORT_W-1:0] pd;    // pull-down enable
  } mio_pads_t;

  typedef enum logic [3:0] {
    PWR_ACTIVE = 4'h1,
    PWR_LIGHT = 4'h2,
    PWR_MEDIUM = 4'h4,
    PWR_DEEP = 4'h8
  } mio_pwr_t;

endpackage : mio_pkg
